// File: sfrc_ctrl.sv
// Supply fault reaction, switching clock generation and register slave
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`include "sfrc_regs.svh"
`default_nettype none
module sfrc_ctrl
   import sfrc_pkg::*;
#(
   parameter int unsigned OT_OFF_CYC = `SFRC_OT_OFF_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic freq_range_strap,
   input wire logic ext_reg_config_strap,
   input wire sfrc_mon_s mon_in,
   output logic buck_sw,
   output logic boost_sw,
   output logic sync_clock_out,
   output logic ext_reg_enable_out,
   output logic mcu_supply_regulator,
   output logic reset_out_n,
   output logic ot_warn_irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam logic [7:0] HI_HALF = 8'(`SFRC_HI_HALF);
   localparam logic [7:0] LO_HALF = 8'(`SFRC_LO_HALF);
   localparam logic [7:0] BOOST_HALF = 8'(`SFRC_BOOST_HALF);
   localparam logic [15:0] STG_CYC = 16'(`SFRC_STG_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] fre_sync_q;
   logic [1:0] sec_sync_q;
   sfrc_mon_s mon_s1_q;
   sfrc_mon_s mon_q;
   logic [1:0] strap_settle_q;
   logic strap_hi_q;
   logic strap_sec_q;
   logic strap_done_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fre_sync_q <= 2'b00;
         sec_sync_q <= 2'b00;
         mon_s1_q <= '0;
         mon_q <= '0;
      end else if (clk_en) begin
         fre_sync_q <= {fre_sync_q[0], freq_range_strap};
         sec_sync_q <= {sec_sync_q[0], ext_reg_config_strap};
         mon_s1_q <= mon_in;
         mon_q <= mon_s1_q;
      end
   end

   // Sync chain needs two edges to fill before the straps can be trusted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_settle_q <= 2'b00;
      end else if (clk_en && !strap_settle_q[1]) begin
         strap_settle_q <= 2'(strap_settle_q + 2'b01);
      end
   end

   // Straps latched once after reset release; pins are high when open
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_hi_q <= 1'b0;
         strap_sec_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (clk_en && !strap_done_q && strap_settle_q[1]) begin
         strap_hi_q <= fre_sync_q[1];
         strap_sec_q <= sec_sync_q[1];
         strap_done_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] ctrl_q;
   logic [5:0] flags_q;
   sfrc_state_e state_q;
   sfrc_state_e state_d;

   wire logic [7:0] trim = ctrl_q[`SFRC_CTRL_TRIM_LSB +: 8];
   wire logic spread_en = ctrl_q[`SFRC_CTRL_SPREAD];
   wire logic sync_invert = ctrl_q[`SFRC_CTRL_PHASE];

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator: free running, no external lock input exists
   logic [7:0] osc_cnt_q;
   logic buck_q;
   logic [7:0] boost_cnt_q;
   logic boost_q;
   logic [3:0] spread_q;

   // Trim is a signed offset on the half period; spread adds a slow ramp
   wire logic [7:0] base_half = strap_hi_q ? HI_HALF : LO_HALF;
   wire logic [7:0] trim_half = 8'(base_half + trim);
   wire logic [7:0] sprd_half = spread_en ? 8'(trim_half + {6'd0, spread_q[3:2]}) : trim_half;
   wire logic [7:0] half = (sprd_half < 8'h02) ? 8'h02 : sprd_half;
   wire logic osc_wrap = osc_cnt_q >= 8'(half - 8'h01);
   wire logic boost_wrap = boost_cnt_q >= 8'(BOOST_HALF - 8'h01);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_cnt_q <= 8'h00;
         buck_q <= 1'b0;
         spread_q <= 4'h0;
      end else if (clk_en) begin
         osc_cnt_q <= osc_wrap ? 8'h00 : 8'(osc_cnt_q + 8'h01);
         if (osc_wrap) begin
            buck_q <= ~buck_q;
            if (buck_q) begin
               spread_q <= 4'(spread_q + 4'h1);
            end
         end
      end
   end

   // Boost at its own rate; parked low in low range, where it would not be slower
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boost_cnt_q <= 8'h00;
         boost_q <= 1'b0;
      end else if (clk_en) begin
         boost_cnt_q <= boost_wrap ? 8'h00 : 8'(boost_cnt_q + 8'h01);
         if (boost_wrap && !strap_hi_q) begin
            boost_q <= 1'b0;
         end else if (boost_wrap) begin
            boost_q <= ~boost_q;
         end
      end
   end

   // Sync takes the next buck level on the same edge as buck_sw
   wire logic buck_next = osc_wrap ? ~buck_q : buck_q;
   wire logic sync_allow = strap_sec_q && !mon_q.pfm;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_clock_out <= 1'b0;
      end else if (clk_en) begin
         sync_clock_out <= sync_allow ? (buck_next ^ sync_invert) : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault reaction state machine
   logic [15:0] stg_cnt_q;
   logic [31:0] ot_cnt_q;
   logic ot_wait_q;

   logic s_wr_ctrl;
   logic [31:0] s_wdata_q;
   // Counter rearms after expiry; the safe state keeps the outcome
   wire logic stg_expired = mon_q.uv && stg_cnt_q >= 16'(STG_CYC - 16'h0001);
   // Off time runs from the end of the shutdown input, so it only lengthens
   wire logic ot_done = ot_cnt_q >= 32'(OT_OFF_CYC - 1);
   // One-cycle strobe; the bit is never stored, so no later write replays it
   wire logic restart_req = s_wr_ctrl && s_wdata_q[`SFRC_CTRL_RESTART];

   always_comb begin
      state_d = state_q;
      case (state_q)
         SFRC_ST_INIT: begin
            if (mon_q.ot_shut || mon_q.ov || stg_expired) begin
               state_d = SFRC_ST_SAFE;
            end else if (ctrl_q[`SFRC_CTRL_STBY]) begin
               state_d = SFRC_ST_STBY;
            end else if (!mon_q.uv) begin
               state_d = SFRC_ST_NORMAL;
            end
         end
         SFRC_ST_NORMAL: begin
            if (mon_q.ot_shut || mon_q.ov) begin
               state_d = SFRC_ST_SAFE;
            end else if (mon_q.uv) begin
               state_d = SFRC_ST_INIT;
            end else if (ctrl_q[`SFRC_CTRL_STBY]) begin
               state_d = SFRC_ST_STBY;
            end
         end
         SFRC_ST_STBY: begin
            if (!ctrl_q[`SFRC_CTRL_STBY]) begin
               state_d = SFRC_ST_INIT;
            end
         end
         SFRC_ST_SAFE: begin
            if (restart_req) begin
               state_d = ot_wait_q ? SFRC_ST_OTWAIT : SFRC_ST_INIT;
            end
         end
         SFRC_ST_OTWAIT: begin
            if (ot_done) begin
               state_d = SFRC_ST_INIT;
            end
         end
         default: state_d = SFRC_ST_SAFE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= SFRC_ST_INIT;
         stg_cnt_q <= 16'h0000;
         ot_cnt_q <= 32'h0000_0000;
         ot_wait_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         stg_cnt_q <= mon_q.uv && !stg_expired ? 16'(stg_cnt_q + 16'h0001) : 16'h0000;
         if (mon_q.ot_shut) begin
            ot_wait_q <= 1'b1;
            ot_cnt_q <= 32'h0000_0000;
         end else if (ot_wait_q && !ot_done) begin
            ot_cnt_q <= ot_cnt_q + 32'h0000_0001;
         end else if (ot_done && state_q == SFRC_ST_OTWAIT) begin
            ot_wait_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Regulator and reset outputs follow the next state so a reaction lands one edge sooner
   wire logic run_ok = state_d == SFRC_ST_NORMAL || state_d == SFRC_ST_INIT;
   wire logic mcu_on = run_ok && ctrl_q[`SFRC_CTRL_MCU_EN];
   // External regulator stays off until software clears its overvoltage flag
   wire logic ext_ov_hold = flags_q[`SFRC_ST_EXT_OV] || mon_q.ext_ov;
   wire logic ext_on = run_ok && ctrl_q[`SFRC_CTRL_EXT_EN] && !ext_ov_hold;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mcu_supply_regulator <= 1'b0;
         ext_reg_enable_out <= 1'b0;
         reset_out_n <= 1'b0;
         ot_warn_irq <= 1'b0;
         buck_sw <= 1'b0;
         boost_sw <= 1'b0;
      end else if (clk_en) begin
         mcu_supply_regulator <= mcu_on;
         ext_reg_enable_out <= ext_on;
         reset_out_n <= state_d == SFRC_ST_NORMAL;
         ot_warn_irq <= mon_q.ot_warn;
         buck_sw <= buck_next;
         boost_sw <= boost_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags: sticky, write one to clear, a new event wins
   wire logic [5:0] flag_set = {mon_q.ext_ov, mon_q.ot_shut, mon_q.ot_warn,
                                mon_q.uv, mon_q.ov, stg_expired};
   logic s_wr_stat;
   logic [5:0] flag_clr;
   assign flag_clr = s_wr_stat ? s_wdata_q[5:0] : 6'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= 6'h00;
      end else if (clk_en) begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic aw_q;
   logic w_q;
   logic [7:0] awaddr_q;
   logic [3:0] wstrb_q;

   wire logic wr_go = aw_q && w_q && !s_axi_bvalid;
   wire logic wr_hit = awaddr_q == `SFRC_CTRL_OFF || awaddr_q == `SFRC_STAT_OFF;
   assign s_wr_ctrl = wr_go && awaddr_q == `SFRC_CTRL_OFF;
   assign s_wr_stat = wr_go && awaddr_q == `SFRC_STAT_OFF && wstrb_q[0];
   wire logic [31:0] strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire logic [31:0] stat_word = {15'h0000, state_q, 3'h0, strap_hi_q, 2'h0, flags_q};
   // Reads decode the aligned word, as writes do
   wire logic [7:0] araddr_w = {s_axi_araddr[7:2], 2'b00};
   wire logic rd_ctrl = araddr_w == `SFRC_CTRL_OFF;
   wire logic rd_stat = araddr_w == `SFRC_STAT_OFF;
   wire logic [31:0] rd_word = rd_ctrl ? ctrl_q : (rd_stat ? stat_word : 32'h0000_0000);

   // Readies drop with clk_en so no beat is lost while state is frozen
   assign s_axi_awready = !aw_q && clk_en;
   assign s_axi_wready = !w_q && clk_en;
   assign s_axi_arready = !s_axi_rvalid && clk_en;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wstrb_q <= 4'h0;
         s_wdata_q <= 32'h0000_0000;
         ctrl_q <= `SFRC_CTRL_RST;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            s_wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (s_wr_ctrl) begin
            ctrl_q <= ((ctrl_q & ~strb_mask) | (s_wdata_q & strb_mask)) &
                      ~(32'h0000_0001 << `SFRC_CTRL_RESTART);
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_ctrl || rd_stat) ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : sfrc_ctrl
`default_nettype wire

// File: sfrc_regs.svh
// Register offsets, fields, reset values and timing counts of the supply fault reaction block
`ifndef SFRC_REGS_SVH
`define SFRC_REGS_SVH
`define SFRC_CTRL_OFF 8'h00
`define SFRC_STAT_OFF 8'h04
`define SFRC_CTRL_RST 32'h0000_0000
`define SFRC_CTRL_MCU_EN 0
`define SFRC_CTRL_EXT_EN 1
`define SFRC_CTRL_SPREAD 2
`define SFRC_CTRL_PHASE 3
`define SFRC_CTRL_STBY 4
`define SFRC_CTRL_RESTART 5
`define SFRC_CTRL_TRIM_LSB 8
`define SFRC_ST_STG 0
`define SFRC_ST_OV 1
`define SFRC_ST_UV 2
`define SFRC_ST_OTW 3
`define SFRC_ST_OTF 4
`define SFRC_ST_EXT_OV 5
`define SFRC_ST_RANGE 8
`define SFRC_ST_STATE_LSB 12
`define SFRC_CLK_HZ 100000000
`define SFRC_HI_KHZ 2200
`define SFRC_LO_KHZ 400
`define SFRC_BOOST_KHZ 500
`define SFRC_HI_HALF ((`SFRC_CLK_HZ / 1000) / (2 * `SFRC_HI_KHZ))
`define SFRC_LO_HALF ((`SFRC_CLK_HZ / 1000) / (2 * `SFRC_LO_KHZ))
`define SFRC_BOOST_HALF ((`SFRC_CLK_HZ / 1000) / (2 * `SFRC_BOOST_KHZ))
`define SFRC_STG_US 200
`define SFRC_STG_CYC ((`SFRC_STG_US * (`SFRC_CLK_HZ / 1000000)))
`define SFRC_OT_OFF_MS 1000
`define SFRC_OT_OFF_CYC ((`SFRC_OT_OFF_MS * (`SFRC_CLK_HZ / 1000)))
`endif

// File: sfrc_pkg.sv
// Types shared by the supply fault reaction block
`default_nettype none
package sfrc_pkg;
   typedef enum logic [4:0] {
      SFRC_ST_INIT = 5'b00001,
      SFRC_ST_NORMAL = 5'b00010,
      SFRC_ST_SAFE = 5'b00100,
      SFRC_ST_STBY = 5'b01000,
      SFRC_ST_OTWAIT = 5'b10000
   } sfrc_state_e;
   typedef struct packed {
      logic ov;
      logic uv;
      logic ot_warn;
      logic ot_shut;
      logic ext_ov;
      logic pfm;
   } sfrc_mon_s;
endpackage : sfrc_pkg
`default_nettype wire

// File: sfrc_ctrl_checker.sv
// Port-level assertions for the supply fault reaction block
`include "sfrc_regs.svh"
`default_nettype none
module sfrc_ctrl_checker
   import sfrc_pkg::*;
#(
   parameter int unsigned OT_OFF_CYC = 50
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_reg_config_strap,
   input wire sfrc_mon_s mon_in,
   input wire logic sync_clock_out,
   input wire logic ext_reg_enable_out,
   input wire logic mcu_supply_regulator,
   input wire logic reset_out_n,
   input wire logic ot_warn_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STG = `SFRC_STG_CYC;
   logic [31:0] uv_cnt_q;
   logic [31:0] ot_cnt_q;
   logic ot_prev_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Off time counted from shutdown entry, so a late falling input cannot excuse it
   always_ff @(posedge aclk) begin
      ot_prev_q <= aresetn && mon_in.ot_shut;
      uv_cnt_q <= (!aresetn || !mon_in.uv) ? '0 : uv_cnt_q + 32'(uv_cnt_q < STG + 8);
      ot_cnt_q <= !aresetn ? 32'(OT_OFF_CYC) : (mon_in.ot_shut && !ot_prev_q) ? '0 :
         ot_cnt_q + 32'(ot_cnt_q < OT_OFF_CYC);
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_SYNC_OFF: assert property (!ext_reg_config_strap [*8] |-> !sync_clock_out)
      else $error("sync output active with strap grounded");
   AST_PFM_SYNC: assert property (mon_in.pfm [*5] |-> !sync_clock_out)
      else $error("sync output active in pulse-frequency mode");
   AST_OV: assert property ($rose(mon_in.ov) |-> ##[1:4] (!mcu_supply_regulator && !reset_out_n))
      else $error("overvoltage did not shut the supply");
   AST_UV_RST: assert property ($rose(mon_in.uv) |-> ##[1:4] !reset_out_n)
      else $error("undervoltage did not pull reset low");
   AST_UV_KEEP: assert property ($rose(mon_in.uv) && mcu_supply_regulator && !mon_in.ov &&
      !mon_in.ot_shut |=> mcu_supply_regulator [*8]) else $error("regulator dropped on short undervoltage");
   AST_STG: assert property (uv_cnt_q == STG + 8 |-> !mcu_supply_regulator && !reset_out_n)
      else $error("lasting undervoltage did not reach safe state");
   AST_OT_SHUT: assert property ($rose(mon_in.ot_shut) |-> ##[1:4]
      (!mcu_supply_regulator && !ext_reg_enable_out && !reset_out_n)) else $error("no thermal shutdown");
   AST_OT_HOLD: assert property (ot_cnt_q >= 4 && ot_cnt_q < OT_OFF_CYC |-> !mcu_supply_regulator)
      else $error("regulator back on inside thermal off time");
   AST_WARN: assert property ($rose(mon_in.ot_warn) |-> ##[1:4] ot_warn_irq)
      else $error("temperature warning not signalled");
   AST_EXT_OV: assert property ($rose(mon_in.ext_ov) |-> ##[1:4] !ext_reg_enable_out)
      else $error("external regulator left on at overvoltage");
endmodule : sfrc_ctrl_checker
bind sfrc_ctrl sfrc_ctrl_checker #(.OT_OFF_CYC(OT_OFF_CYC)) u_checker (.aclk, .aresetn,
   .ext_reg_config_strap, .mon_in, .sync_clock_out, .ext_reg_enable_out,
   .mcu_supply_regulator, .reset_out_n, .ot_warn_irq);
`default_nettype wire

// File: sfrc_partner.sv
// External post regulator model facing the supply fault reaction block
`default_nettype none
module sfrc_partner (
   input wire logic aclk,
   input wire logic fitted,
   input wire logic inject_ov,
   input wire logic ext_reg_enable_out,
   output logic ext_reg_config_strap,
   output logic ext_ov
);
   timeunit 1ns;
   timeprecision 1ps;
   logic on_q;
   assign ext_reg_config_strap = fitted;
   // Output can only overshoot while the regulator is actually running
   always_ff @(posedge aclk) on_q <= fitted && ext_reg_enable_out;
   assign ext_ov = inject_ov && on_q;
endmodule : sfrc_partner
`default_nettype wire

// File: test_supply_fault_reaction_ctrl.sv
// Self-checking bench for the supply fault reaction block
`include "sfrc_regs.svh"
`default_nettype none
module test_supply_fault_reaction_ctrl
   import sfrc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OTC = 50;
   localparam logic [7:0] CT = `SFRC_CTRL_OFF;
   localparam logic [7:0] ST = `SFRC_STAT_OFF;
   logic aclk, aresetn = 0, freq_range_strap = 1, fitted = 1, inject_ov = 0, sel = 0, s;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, buck_sw, boost_sw, sync_clock_out, ext_reg_enable_out, ot_warn_irq;
   logic mcu_supply_regulator, reset_out_n, ext_reg_config_strap, ext_ov;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, p, q;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int mismatches = 0, total_checks = 0, cyc = 0;
   sfrc_mon_s mon = '0;
   wire sfrc_mon_s mon_w = {mon[5:2], ext_ov, mon[0]};
   wire logic sw = sel ? boost_sw : buck_sw;
   sfrc_ctrl #(.OT_OFF_CYC(OTC)) dut (.aclk, .aresetn, .clk_en(1'h1), .freq_range_strap,
      .ext_reg_config_strap, .mon_in(mon_w), .buck_sw, .boost_sw, .sync_clock_out,
      .ext_reg_enable_out, .mcu_supply_regulator, .reset_out_n, .ot_warn_irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   sfrc_partner u_partner (.aclk, .fitted, .inject_ov, .ext_reg_enable_out,
      .ext_reg_config_strap, .ext_ov);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   // One full switching period, starting at a rising edge
   task automatic per(output logic [31:0] n);
      while (sw === 1'h1) @(posedge aclk);
      while (sw !== 1'h1) @(posedge aclk);
      n = '0;
      while (sw === 1'h1) begin
         @(posedge aclk);
         n++;
      end
      while (sw !== 1'h1) begin
         @(posedge aclk);
         n++;
      end
   endtask : per
   // Sampled five cycles into the high phase, clear of any register slip between the two clocks
   task automatic sync_mid(output logic r);
      while (buck_sw === 1'h1) @(posedge aclk);
      while (buck_sw !== 1'h1) @(posedge aclk);
      repeat (5) @(posedge aclk);
      r = sync_clock_out;
   endtask : sync_mid
   task automatic sync_any(output logic r);
      r = 1'h0;
      repeat (300) begin
         @(posedge aclk);
         r |= sync_clock_out;
      end
   endtask : sync_any
   task automatic wait_norm;
      for (int i = 0; i < 3000 && reset_out_n !== 1'h1; i++) @(posedge aclk);
   endtask : wait_norm
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      rd(CT, v);
      chk(v, `SFRC_CTRL_RST);
      rd(ST, v);
      chk(32'(v[`SFRC_ST_RANGE]), 32'h1);
      wr(8'h10, 32'h0000_0003);
      chk(32'(resp), 32'h2);
      rd(8'h10, v);
      chk(v | 32'(resp), 32'h2);
      per(p);
      chk(p, 2 * `SFRC_HI_HALF);
      chk(32'(p >= 40 && p <= 50), 32'h1);
      sel = 1'h1;
      per(q);
      chk(32'(q > p), 32'h1);
      sel = 1'h0;
      wr(CT, 32'h0000_0203);
      per(q);
      chk(q - p, 32'h4);
      wr(CT, 32'h0000_0003);
      wait_norm();
      chk({reset_out_n, mcu_supply_regulator, ext_reg_enable_out}, 32'h7);
      sync_mid(s);
      chk(32'(s), 32'h1);
      wr(CT, 32'h0000_000b);
      sync_mid(s);
      chk(32'(s), 32'h0);
      mon.pfm <= 1'h1;
      repeat (4) @(posedge aclk);
      sync_any(s);
      chk(32'(s), 32'h0);
      mon.pfm <= 1'h0;
      inject_ov <= 1'h1;
      repeat (5) @(posedge aclk);
      chk(32'(ext_reg_enable_out), 32'h0);
      inject_ov <= 1'h0;
      rd(ST, v);
      chk(32'(v[`SFRC_ST_EXT_OV]), 32'h1);
      chk(32'(ext_reg_enable_out), 32'h0);
      wr(ST, 32'h0000_0020);
      repeat (4) @(posedge aclk);
      chk(32'(ext_reg_enable_out), 32'h1);
      mon.uv <= 1'h1;
      repeat (4) @(posedge aclk);
      chk({reset_out_n, mcu_supply_regulator}, 32'h1);
      mon.uv <= 1'h0;
      rd(ST, v);
      chk(32'(v[`SFRC_ST_UV]), 32'h1);
      wait_norm();
      mon.uv <= 1'h1;
      repeat (`SFRC_STG_CYC + 10) @(posedge aclk);
      chk({reset_out_n, mcu_supply_regulator}, 32'h0);
      mon.uv <= 1'h0;
      rd(ST, v);
      chk(32'(v[`SFRC_ST_STG]), 32'h1);
      wr(CT, 32'h0000_002b);
      wait_norm();
      mon.ov <= 1'h1;
      repeat (4) @(posedge aclk);
      chk({reset_out_n, mcu_supply_regulator, ext_reg_enable_out}, 32'h0);
      mon.ov <= 1'h0;
      rd(ST, v);
      chk(32'({v[16:12], v[`SFRC_ST_OV]}), 32'h9);
      wr(CT, 32'h0000_002b);
      wait_norm();
      mon.ot_warn <= 1'h1;
      repeat (4) @(posedge aclk);
      chk(32'(ot_warn_irq), 32'h1);
      mon.ot_warn <= 1'h0;
      mon.ot_shut <= 1'h1;
      repeat (4) @(posedge aclk);
      chk({reset_out_n, mcu_supply_regulator, ext_reg_enable_out}, 32'h0);
      mon.ot_shut <= 1'h0;
      rd(ST, v);
      chk(32'({v[`SFRC_ST_OTF], v[`SFRC_ST_OTW]}), 32'h3);
      wr(CT, 32'h0000_002b);
      chk(32'(mcu_supply_regulator), 32'h0);
      repeat (OTC) @(posedge aclk);
      wr(CT, 32'h0000_002b);
      wait_norm();
      wr(CT, 32'h0000_0013);
      repeat (4) @(posedge aclk);
      chk(32'(mcu_supply_regulator), 32'h0);
      aresetn <= 1'h0;
      freq_range_strap <= 1'h0;
      fitted <= 1'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (4) @(posedge aclk);
      rd(ST, v);
      chk(32'(v[`SFRC_ST_RANGE]), 32'h0);
      per(p);
      chk(p, 2 * `SFRC_LO_HALF);
      chk(32'(p >= 200 && p <= 333), 32'h1);
      wr(CT, 32'h0000_0003);
      sync_any(s);
      chk(32'(s), 32'h0);
      complete_run();
   end
endmodule : test_supply_fault_reaction_ctrl
`default_nettype wire
